// ==== rtl/bma_pkg.sv ====
// package: constants and types for the bus mastership acquisition block
package bma_pkg;
  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;
  // reset values of the pin drivers
  localparam logic RST_REQ_OE = 1'b0;
  localparam logic RST_ACK_OE = 1'b0;
  localparam logic RST_DIR_OE = 1'b0;
  localparam logic RST_INT_OE = 1'b0;
  // width of the interrupt source vector
  localparam int INT_SRC_W = 16;
  localparam logic [INT_SRC_W-1:0] RST_INT_SRC = 16'h0000;
  // arbitration states
  typedef enum logic [1:0] {
    BMA_IDLE,
    BMA_REQ,
    BMA_OWN
  } bma_state_t;
endpackage : bma_pkg

// ==== rtl/bma_top.sv ====
// bus mastership acquisition, direction and interrupt pin logic
// Contract
// - while owning the bus, direction pin is high for read, low for write
// - interrupt pin pulled low while any enabled pending source exists
// - masked pending sources never activate the interrupt pin
// - bus request pin pulled low in the 68000-style bus mode while the bus is needed and not yet owned
// - bus request pin released (not driven) when not requesting
// - ownership acknowledge driven low only after all checks pass
// - a grant must have been received before acknowledging
// - address strobe must be deasserted before acknowledging
// - both slave size acknowledges must be deasserted before acknowledging
// - ownership acknowledge line must be deasserted before acknowledging
// - address strobe fall marks valid address, rise marks end of cycle
`timescale 1ns/1ps
module bma_top
  import bma_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // mode and transfer control from internal dma
  input wire logic i_bus_style_select,
  input wire logic i_xfer_need,
  input wire logic i_xfer_read,
  input wire logic i_xfer_done,
  // interrupt status and mask from internal registers
  input wire logic [bma_pkg::INT_SRC_W-1:0] i_int_status,
  input wire logic [bma_pkg::INT_SRC_W-1:0] i_int_mask,
  // arbitration pins
  input wire logic i_grant_in_n,
  input wire logic i_addr_valid_strobe_n,
  input wire logic i_slave_size_ack_lo_n,
  input wire logic i_slave_size_ack_hi_n,
  input wire logic i_ownership_ack_n,
  output logic o_bus_req_n,
  output logic o_bus_req_n_oe,
  output logic o_ownership_ack_n,
  output logic o_ownership_ack_n_oe,
  output logic o_mem_dir_strobe,
  output logic o_mem_dir_strobe_oe,
  // interrupt pin
  output logic o_int_n,
  output logic o_int_n_oe,
  // status
  output logic o_owner
);
  import bma_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change taken when stages two and three agree
  logic [3:0] pin_raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] pin_q;
  assign pin_raw = {i_ownership_ack_n, i_slave_size_ack_hi_n,
                    i_slave_size_ack_lo_n, i_addr_valid_strobe_n};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
          s3_q[gi] <= 1'b1;
          pin_q[gi] <= 1'b1;
        end
        else
        begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            pin_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  logic grant_s1_q;
  logic grant_s2_q;
  logic grant_s3_q;
  logic grant_q;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      grant_s1_q <= 1'b1;
      grant_s2_q <= 1'b1;
      grant_s3_q <= 1'b1;
      grant_q <= 1'b1;
    end
    else
    begin
      grant_s1_q <= i_grant_in_n;
      grant_s2_q <= grant_s1_q;
      grant_s3_q <= grant_s2_q;
      if (grant_s2_q == grant_s3_q)
        grant_q <= grant_s3_q;
    end
  end

  logic as_free;
  logic slave_free;
  logic master_free;
  logic granted;
  assign as_free = pin_q[0];
  assign slave_free = pin_q[1] & pin_q[2];
  assign master_free = pin_q[3];
  assign granted = ~grant_q;

  ////////////////////////////////////////////////////////////////////////////
  // arbitration state machine, active only in the 68000-style bus mode
  bma_state_t state_q;
  bma_state_t state_d;
  logic take_bus;
  assign take_bus = granted & as_free & slave_free & master_free;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BMA_IDLE:
        if (i_bus_style_select && i_xfer_need)
          state_d = BMA_REQ;
      BMA_REQ:
        if (!i_bus_style_select || !i_xfer_need)
          state_d = BMA_IDLE;
        else if (take_bus)
          state_d = BMA_OWN;
      BMA_OWN:
        if (i_xfer_done || !i_bus_style_select)
          state_d = BMA_IDLE;
      default:
        state_d = BMA_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state_q <= BMA_IDLE;
    else
      state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, registered from the next state
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_bus_req_n <= 1'b1;
      o_bus_req_n_oe <= RST_REQ_OE;
      o_ownership_ack_n <= 1'b1;
      o_ownership_ack_n_oe <= RST_ACK_OE;
      o_mem_dir_strobe <= 1'b1;
      o_mem_dir_strobe_oe <= RST_DIR_OE;
      o_owner <= 1'b0;
    end
    else
    begin
      // open drain request and acknowledge: only ever drive low; direction pin driven both ways
      o_bus_req_n <= 1'b0;
      o_bus_req_n_oe <= (state_d == BMA_REQ);
      o_ownership_ack_n <= 1'b0;
      o_ownership_ack_n_oe <= (state_d == BMA_OWN);
      o_mem_dir_strobe <= i_xfer_read;
      o_mem_dir_strobe_oe <= (state_d == BMA_OWN);
      o_owner <= (state_d == BMA_OWN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin, open collector
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_int_n <= 1'b1;
      o_int_n_oe <= RST_INT_OE;
    end
    else
    begin
      o_int_n <= 1'b0;
      o_int_n_oe <= |(i_int_status & i_int_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_dir_read;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_mem_dir_strobe_oe |-> (o_mem_dir_strobe == $past(i_xfer_read));
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction pin wrong");

  property p_int_on;
    @(posedge i_clk) disable iff (!i_rst_b)
    (|(i_int_status & i_int_mask)) |=> (o_int_n_oe && !o_int_n);
  endproperty
  a_int_on: assert property (p_int_on) else $error("interrupt not raised");

  property p_int_masked;
    @(posedge i_clk) disable iff (!i_rst_b)
    !(|(i_int_status & i_int_mask)) |=> !o_int_n_oe;
  endproperty
  a_int_masked: assert property (p_int_masked) else $error("masked interrupt raised");

  property p_req_low;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_bus_req_n_oe |-> (!o_bus_req_n && !o_ownership_ack_n_oe);
  endproperty
  a_req_low: assert property (p_req_low) else $error("request pin wrong");

  // no need or mode off on one edge leaves the request line released after it
  property p_req_release;
    @(posedge i_clk) disable iff (!i_rst_b)
    $past(!i_xfer_need || !i_bus_style_select) |-> !o_bus_req_n_oe;
  endproperty
  a_req_release: assert property (p_req_release) else $error("request driven idle");

  property p_ack_checks;
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_ownership_ack_n_oe) |->
      $past(granted && as_free && slave_free && master_free);
  endproperty
  a_ack_checks: assert property (p_ack_checks) else $error("ack without checks");

  property p_ack_grant;
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_ownership_ack_n_oe) |-> $past(!grant_q);
  endproperty
  a_ack_grant: assert property (p_ack_grant) else $error("ack without grant");

  property p_ack_as;
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_ownership_ack_n_oe) |-> $past(pin_q[0]);
  endproperty
  a_ack_as: assert property (p_ack_as) else $error("ack while strobe busy");

  property p_ack_slave;
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_ownership_ack_n_oe) |-> $past(pin_q[1] && pin_q[2]);
  endproperty
  a_ack_slave: assert property (p_ack_slave) else $error("ack while slave busy");

  property p_ack_master;
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_ownership_ack_n_oe) |-> $past(pin_q[3]);
  endproperty
  a_ack_master: assert property (p_ack_master) else $error("ack while master busy");

  // leaving the mode, or finishing while owner, lets go of every owner pin
  property p_release;
    @(posedge i_clk) disable iff (!i_rst_b)
    $past(!i_bus_style_select || (i_xfer_done && o_owner)) |->
      (!o_owner && !o_mem_dir_strobe_oe && !o_ownership_ack_n_oe);
  endproperty
  a_release: assert property (p_release) else $error("pins driven not owner");

  c_own: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(o_owner));
  c_wait: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_bus_req_n_oe && granted && !as_free));
  c_int: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(o_int_n_oe));
  c_done: cover property (@(posedge i_clk) disable iff (!i_rst_b) $fell(o_owner));
endmodule : bma_top

// ==== test/bma_arb_model.sv ====
// arbiter and previous bus owner model facing the mastership pins
`timescale 1ns/1ps
module bma_arb_model
(
  // clock
  input wire logic i_clk,
  // request wire level and which lines the previous owner still holds
  input wire logic i_req_n,
  input wire logic [3:0] i_hold,
  // pins seen by the device
  output logic o_grant_n,
  output logic o_strobe_n,
  output logic o_size_lo_n,
  output logic o_size_hi_n,
  output logic o_prev_ack_n
);
  logic [1:0] lag_q = 2'h3;
  // grant answers a request two edges later and is withdrawn likewise
  always @(posedge i_clk)
    lag_q <= {lag_q[0], i_req_n};
  assign o_grant_n = lag_q[1];
  // lines let go by the previous owner rise to their pull-up level
  assign o_strobe_n = ~i_hold[0];
  assign o_size_lo_n = ~i_hold[1];
  assign o_size_hi_n = ~i_hold[2];
  assign o_prev_ack_n = ~i_hold[3];
endmodule : bma_arb_model

// ==== test/bus_master_acquisition_test.sv ====
// self-checking bench for the bus mastership acquisition block
`timescale 1ns/1ps
module bus_master_acquisition_test;
  import bma_pkg::*;
  logic clk, rst_b, sel, need, rd, done;
  logic [INT_SRC_W-1:0] st, mk;
  logic [3:0] hold;
  logic grant_n, strobe_n, lo_n, hi_n, prev_ack_n, ack_wire_n, req_wire_n;
  logic req_n, req_oe, ack_n, ack_oe, dir, dir_oe, int_n, int_oe, owner;
  int bad_count, checks_done, n;
  // wire levels resolved from every party's drive
  assign req_wire_n = req_oe ? req_n : 1'b1;
  assign ack_wire_n = (ack_oe ? ack_n : 1'b1) & prev_ack_n;
  bma_top dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_bus_style_select(sel),
    .i_xfer_need(need), .i_xfer_read(rd), .i_xfer_done(done), .i_int_status(st),
    .i_int_mask(mk), .i_grant_in_n(grant_n), .i_addr_valid_strobe_n(strobe_n),
    .i_slave_size_ack_lo_n(lo_n), .i_slave_size_ack_hi_n(hi_n),
    .i_ownership_ack_n(ack_wire_n), .o_bus_req_n(req_n), .o_bus_req_n_oe(req_oe),
    .o_ownership_ack_n(ack_n), .o_ownership_ack_n_oe(ack_oe), .o_mem_dir_strobe(dir),
    .o_mem_dir_strobe_oe(dir_oe), .o_int_n(int_n), .o_int_n_oe(int_oe), .o_owner(owner));
  bma_arb_model arb_u (.i_clk(clk), .i_req_n(req_wire_n), .i_hold(hold),
    .o_grant_n(grant_n), .o_strobe_n(strobe_n), .o_size_lo_n(lo_n),
    .o_size_hi_n(hi_n), .o_prev_ack_n(prev_ack_n));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask : cyc
  task automatic conclude;
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  // pins released after reset and while the mode is off
  task automatic t_idle;
    chk("idle_oe", {req_oe, ack_oe, dir_oe, int_oe}, 4'h0);
    sel = 1'b0;
    need = 1'b1;
    cyc(8);
    chk("off_req_oe", req_oe, 1'b0);
    need = 1'b0;
    sel = 1'b1;
    cyc(2);
  endtask : t_idle
  // one acquisition with the previous owner holding lines for a while
  task automatic t_acquire(input logic rd_v, input logic [3:0] h);
    hold = h;
    rd = rd_v;
    need = 1'b1;
    cyc(2);
    chk("req", {req_oe, req_n}, 2'h2);
    chk("early_ack", ack_oe, 1'b0);
    if (h != 4'h0)
    begin
      cyc(12);
      chk("blocked_ack", {ack_oe, owner}, 2'h0);
      hold = 4'h0;
    end
    n = 0;
    while (owner !== 1'b1 && n < 12)
    begin
      cyc(1);
      n++;
    end
    chk("own_ack", {owner, ack_oe, ack_n}, 3'h6);
    chk("dir", {dir_oe, dir}, {1'b1, rd_v});
    chk("req_free", req_oe, 1'b0);
    need = 1'b0;
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(1);
    chk("released", {ack_oe, dir_oe, owner}, 3'h0);
    cyc(10);
  endtask : t_acquire
  // request withdrawn while blocked, then ownership cut by leaving the mode
  task automatic t_abort;
    hold = 4'h1;
    rd = 1'h1;
    need = 1'h1;
    cyc(14);
    chk("blk_req", {req_oe, ack_oe}, 2'h2);
    need = 1'h0;
    cyc(2);
    chk("drop_req", {req_oe, owner}, 2'h0);
    hold = 4'h0;
    cyc(10);
    need = 1'h1;
    n = 0;
    while (owner !== 1'h1 && n < 12)
    begin
      cyc(1);
      n++;
    end
    chk("re_own", {owner, ack_oe}, 2'h3);
    rd = 1'h0;
    cyc(1);
    chk("dir_follow", {dir_oe, dir}, 2'h2);
    sel = 1'h0;
    need = 1'h0;
    cyc(1);
    chk("mode_off", {owner, ack_oe, dir_oe, req_oe}, 4'h0);
    sel = 1'h1;
    cyc(10);
  endtask : t_abort
  // enabled sources raise the line, masked ones never do
  task automatic t_int(input logic [15:0] s, input logic [15:0] m);
    st = s;
    mk = m;
    cyc(2);
    chk("int", {int_oe, int_n}, ((s & m) != 16'h0000) ? 2'h2 : 2'h0);
  endtask : t_int
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #200000;
    bad_count++;
    conclude();
  end
  initial
  begin
    {rst_b, need, rd, done} = 4'h0;
    sel = 1'b1;
    st = 16'h0000;
    mk = 16'h0000;
    hold = 4'h0;
    repeat (4) @(posedge clk);
    #5;
    rst_b = 1'b1;
    cyc(2);
    t_idle();
    t_acquire(1'b1, 4'h0);
    t_acquire(1'b0, 4'h1);
    t_acquire(1'b1, 4'h2);
    t_acquire(1'b0, 4'h4);
    t_acquire(1'b1, 4'h8);
    t_abort();
    t_int(16'h0010, 16'h0000);
    t_int(16'h0010, 16'h0010);
    t_int(16'h8001, 16'h7FFE);
    t_int(16'h8001, 16'h8000);
    t_int(16'h0000, 16'hFFFF);
    conclude();
  end
endmodule : bus_master_acquisition_test
